// ==== logic/drv_regs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words at byte addresses
// Notes:   included by the top level, the checker and the bench
`ifndef DRV_REGS_SVH
`define DRV_REGS_SVH

// register byte addresses
`define DRV_CTRL0_ADDR    8'h00
`define DRV_CTRL1_ADDR    8'h04
`define DRV_STAT0_ADDR    8'h08
`define DRV_STAT1_ADDR    8'h0c

// control word 0 fields
`define DRV_ON_LSB        0
`define DRV_DUTY_BIT      16
`define DRV_MON_ALT_BIT   17
`define DRV_MON_SEL_LSB   18
`define DRV_RECOV_DIS_BIT 20
`define DRV_ACTIVE_BIT    23

// control word 1 and status word 0 fields
`define DRV_LOW_LSB       0
`define DRV_HIGH_LSB      16

// status word 1 fields
`define DRV_OV_BIT        0
`define DRV_UV_BIT        1
`define DRV_TW_BIT        2
`define DRV_TSD_BIT       3
`define DRV_ST_ACTIVE_BIT 4

// reset value of every register
`define DRV_REG_RESET     32'h0000_0000

// timing
`define DRV_CLK_NS        5
`define DRV_DIAG_FILT_NS  32000
`define DRV_OL_FILT_NS    1000000
`define DRV_OFF_MULT_12   7
`define DRV_OFF_MULT_25   3

`endif

// ==== logic/drv_pkg.sv ====
// Purpose: shared types of the driver protection block
// Assumes: eleven output stages
// Notes:   numbers live in drv_regs.svh
package drv_pkg;

    typedef struct packed {
        logic        active;
        logic        recov_dis;
        logic [1:0]  mon_sel;
        logic        mon_alt;
        logic        duty_long;
        logic [10:0] on;
    } ctrl0_s;

    // ov in bit 0, matching the synchroniser slice and status word 1
    typedef struct packed {
        logic tsd;
        logic tw;
        logic uv;
        logic ov;
    } supply_s;

endpackage

// ==== logic/diag_filter.sv ====
// Purpose: persistence filter for one raw diagnostic condition
// Assumes: raw already synchronised to ref_clk
// Notes:   hit stays high while the condition persists past LIMIT
module diag_filter #(
    parameter int LIMIT = 6400
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // condition
    input  wire logic raw,
    input  wire logic enable,
    output logic      hit
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    always_comb begin
        cnt_next = '0;
        if (raw && enable) begin
            cnt_next = (cnt_reg == LIM) ? cnt_reg : cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign hit = (cnt_reg == LIM);
endmodule

// ==== logic/recovery_timer.sv ====
// Purpose: over-current trip state of one driver with optional recovery
// Assumes: trip is the filtered over-current level
// Notes:   off time is a multiple of the filter time, giving the duty
module recovery_timer #(
    parameter int OFF_SHORT = 19200,
    parameter int OFF_LONG  = 44800
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // control
    input  wire logic trip,
    input  wire logic flag_clr,
    input  wire logic recov_en,
    input  wire logic duty_long,
    input  wire logic kill,
    output logic      tripped
);
    localparam int CW = $clog2(OFF_LONG + 1);

    logic          trip_reg;
    logic          trip_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [CW-1:0] off_len;

    assign off_len = duty_long ? CW'(OFF_SHORT) : CW'(OFF_LONG);

    always_comb begin
        trip_next = trip_reg;
        cnt_next  = '0;
        if (kill) begin
            trip_next = 1'b0;
        end else if (trip) begin
            trip_next = 1'b1;
        end else if (trip_reg && recov_en) begin
            cnt_next = cnt_reg + CW'(1);
            if (cnt_reg >= off_len - CW'(1)) begin
                trip_next = 1'b0;
                cnt_next  = '0;
            end
        end else if (flag_clr) begin
            trip_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            trip_reg <= 1'b0;
            cnt_reg  <= '0;
        end else begin
            trip_reg <= trip_next;
            cnt_reg  <= cnt_next;
        end
    end

    assign tripped = trip_reg;
endmodule

// ==== logic/driver_protection_diagnostics.sv ====
// Purpose: mode, protection and diagnostic logic of an 11-output driver bank
// Assumes: analog comparators arrive asynchronously; registers on a plain port
// Notes:   out_enable low means the stage is in high impedance
// How it works
// - low logic supply forces every output off and clears all status.
// - writing bit 23 low enters standby and clears latched data.
// - writing bit 23 high makes the device active.
// - diagnostic flags other than open load set only after 32 us of unbroken condition.
// - open load sets its flag after 1 ms of low current.
// - open load is watched only on stages that are switched on.
// - open load and temperature warning never switch drivers.
// - filtered over-current sets its flag and switches off that driver.
// - without recovery a tripped driver waits for its flag to be cleared.
// - supply overvoltage puts all eleven outputs in high impedance.
// - supply undervoltage puts all outputs in high impedance.
// - with bit 20 low outputs return by themselves after supply recovers.
// - with bit 20 high outputs return only after software clears flags.
// - first temperature threshold sets a readable warning flag.
// - second threshold sets shutdown flag and switches all stages off.
// - stages return after cooling and software clearing the shutdown flag.
// - bits 18 and 19 pick the stage routed to the current monitor.
// - monitor pin is two-way, also the second pulse-width input.
// - all modes set and all diagnostics read through the register port.
// - with recovery set a tripped driver restarts at 12 or 25 % duty.
// - with pulse enable set an output is its bit ANDed with its pulse input.
`include "drv_regs.svh"
module driver_protection_diagnostics
    import drv_pkg::*;
#(
    parameter int NUM_OUT      = 11,
    parameter int DIAG_FILT_CYC =
        (`DRV_DIAG_FILT_NS + `DRV_CLK_NS - 1) / `DRV_CLK_NS,
    parameter int OL_FILT_CYC  =
        (`DRV_OL_FILT_NS + `DRV_CLK_NS - 1) / `DRV_CLK_NS
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    // analog comparators, asynchronous
    input  wire logic               logic_supply_low,
    input  wire logic [NUM_OUT-1:0] overcurrent_raw,
    input  wire logic [NUM_OUT-1:0] open_load_raw,
    input  wire logic               supply_overvoltage_raw,
    input  wire logic               supply_undervoltage_raw,
    input  wire logic               temp_warning_raw,
    input  wire logic               temp_shutdown_raw,
    // pulse-width inputs and monitor pin
    input  wire logic               first_pulse_width_input,
    input  wire logic               monitor_and_second_pulse_pin_in,
    output logic                    monitor_and_second_pulse_pin_out,
    output logic                    monitor_and_second_pulse_pin_oe,
    // power stage controls
    output logic      [NUM_OUT-1:0] out_enable,
    output logic      [4:0]         monitor_select
);
    localparam int SW = 2 * NUM_OUT + 7;
    localparam int OFF_SHORT = DIAG_FILT_CYC * `DRV_OFF_MULT_25;
    localparam int OFF_LONG  = DIAG_FILT_CYC * `DRV_OFF_MULT_12;

    // two-flop synchronisers; first stage feeds only the second
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] async_in;

    assign async_in = {monitor_and_second_pulse_pin_in, first_pulse_width_input,
                       logic_supply_low, temp_shutdown_raw, temp_warning_raw,
                       supply_undervoltage_raw, supply_overvoltage_raw,
                       open_load_raw, overcurrent_raw};

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic [NUM_OUT-1:0] oc_s;
    logic [NUM_OUT-1:0] ol_s;
    supply_s            sup_s;
    logic               vcc_low_s;
    logic               first_pulse_width_input_s;
    logic               pwm2_s;

    assign oc_s      = sync2_reg[NUM_OUT-1:0];
    assign ol_s      = sync2_reg[2*NUM_OUT-1:NUM_OUT];
    assign sup_s     = sync2_reg[2*NUM_OUT+3:2*NUM_OUT];
    assign vcc_low_s = sync2_reg[2*NUM_OUT+4];
    assign first_pulse_width_input_s    = sync2_reg[2*NUM_OUT+5];
    assign pwm2_s    = sync2_reg[2*NUM_OUT+6];

    // register state
    ctrl0_s             ctrl0_reg;
    ctrl0_s             ctrl0_next;
    logic [NUM_OUT-1:0] recov_en_reg;
    logic [NUM_OUT-1:0] recov_en_next;
    logic [NUM_OUT-1:0] pwm_en_reg;
    logic [NUM_OUT-1:0] pwm_en_next;
    logic [NUM_OUT-1:0] oc_flag_reg;
    logic [NUM_OUT-1:0] oc_flag_next;
    logic [NUM_OUT-1:0] ol_flag_reg;
    logic [NUM_OUT-1:0] ol_flag_next;
    supply_s            sup_flag_reg;
    supply_s            sup_flag_next;
    logic [31:0]        rdata_reg;
    logic [31:0]        rdata_next;
    logic [NUM_OUT-1:0] out_en_reg;
    logic [NUM_OUT-1:0] out_en_next;
    logic [4:0]         mon_reg;
    logic [4:0]         mon_next;
    logic               mon_oe_reg;
    logic               mon_oe_next;

    // filter results
    logic [NUM_OUT-1:0] oc_hit;
    logic [NUM_OUT-1:0] ol_hit;
    logic [3:0]         sup_hit;
    supply_s            sup_hit_s;
    logic [NUM_OUT-1:0] tripped;
    logic               diag_on;
    logic               clr_all;
    logic               wr_ctrl0;
    logic               wr_ctrl1;
    logic               wr_stat0;
    logic               wr_stat1;
    logic [NUM_OUT-1:0] oc_clr;

    assign wr_ctrl0 = reg_wr && (reg_addr == `DRV_CTRL0_ADDR);
    assign wr_ctrl1 = reg_wr && (reg_addr == `DRV_CTRL1_ADDR);
    assign wr_stat0 = reg_wr && (reg_addr == `DRV_STAT0_ADDR);
    assign wr_stat1 = reg_wr && (reg_addr == `DRV_STAT1_ADDR);
    assign oc_clr   = wr_stat0 ? reg_wdata[`DRV_LOW_LSB +: NUM_OUT] : '0;

    assign clr_all = vcc_low_s || !ctrl0_reg.active;
    assign diag_on = ctrl0_reg.active && !vcc_low_s;
    assign sup_hit_s = sup_hit;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sup
            diag_filter #(.LIMIT(DIAG_FILT_CYC)) u_sup (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .raw     (sup_s[g]),
                .enable  (diag_on),
                .hit     (sup_hit[g])
            );
        end
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            diag_filter #(.LIMIT(DIAG_FILT_CYC)) u_oc (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .raw     (oc_s[g]),
                .enable  (diag_on),
                .hit     (oc_hit[g])
            );
            diag_filter #(.LIMIT(OL_FILT_CYC)) u_ol (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .raw     (ol_s[g]),
                .enable  (diag_on && out_en_reg[g]),
                .hit     (ol_hit[g])
            );
            recovery_timer #(
                .OFF_SHORT (OFF_SHORT),
                .OFF_LONG  (OFF_LONG)
            ) u_rec (
                .ref_clk   (ref_clk),
                .reset_n   (reset_n),
                .trip      (oc_hit[g]),
                .flag_clr  (oc_clr[g]),
                .recov_en  (recov_en_reg[g]),
                .duty_long (ctrl0_reg.duty_long),
                .kill      (clr_all),
                .tripped   (tripped[g])
            );
        end
    endgenerate

    always_comb begin
        ctrl0_next    = ctrl0_reg;
        recov_en_next = recov_en_reg;
        pwm_en_next   = pwm_en_reg;
        if (wr_ctrl0) begin
            ctrl0_next.on        = reg_wdata[`DRV_ON_LSB +: NUM_OUT];
            ctrl0_next.duty_long = reg_wdata[`DRV_DUTY_BIT];
            ctrl0_next.mon_alt   = reg_wdata[`DRV_MON_ALT_BIT];
            ctrl0_next.mon_sel   = reg_wdata[`DRV_MON_SEL_LSB +: 2];
            ctrl0_next.recov_dis = reg_wdata[`DRV_RECOV_DIS_BIT];
            ctrl0_next.active    = reg_wdata[`DRV_ACTIVE_BIT];
        end
        if (wr_ctrl1) begin
            recov_en_next = reg_wdata[`DRV_LOW_LSB +: NUM_OUT];
            pwm_en_next   = reg_wdata[`DRV_HIGH_LSB +: NUM_OUT];
        end
        if (!ctrl0_next.active) begin
            ctrl0_next    = '0;
            recov_en_next = '0;
            pwm_en_next   = '0;
        end
    end

    // status flags; a set in the clearing cycle wins
    always_comb begin
        ol_flag_next  = ol_flag_reg;
        oc_flag_next  = oc_flag_reg & ~oc_clr;
        sup_flag_next = sup_flag_reg;
        if (wr_stat0) begin
            ol_flag_next = ol_flag_reg & ~reg_wdata[`DRV_HIGH_LSB +: NUM_OUT];
        end
        if (wr_stat1) begin
            sup_flag_next = sup_flag_reg & ~reg_wdata[`DRV_OV_BIT +: 4];
        end
        ol_flag_next  = ol_flag_next | ol_hit;
        oc_flag_next  = oc_flag_next | oc_hit;
        sup_flag_next = sup_flag_next | sup_hit_s;
        if (clr_all) begin
            ol_flag_next  = '0;
            oc_flag_next  = '0;
            sup_flag_next = '0;
        end
    end

    // output drive
    logic               supply_block;
    logic               temp_block;
    logic [NUM_OUT-1:0] pwm_gate;

    // auto return; else wait for clear
    assign supply_block = sup_hit_s.ov || sup_hit_s.uv ||
                          (ctrl0_reg.recov_dis && (sup_flag_reg.ov || sup_flag_reg.uv));
    assign temp_block   = sup_hit_s.tsd || sup_flag_reg.tsd;

    // outputs 9 and 10 use the pin input
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_pwm
            if (g == 8 || g == 9) begin : g_p2
                assign pwm_gate[g] = !pwm_en_reg[g] || pwm2_s;
            end else begin : g_p1
                assign pwm_gate[g] = !pwm_en_reg[g] || first_pulse_width_input_s;
            end
        end
    endgenerate

    always_comb begin
        out_en_next = ctrl0_reg.on & pwm_gate & ~tripped;
        // warning and open load not used here
        if (!diag_on || supply_block || temp_block) begin
            out_en_next = '0;
        end
    end

    // monitor routing, one-hot to analog mux
    always_comb begin
        mon_next = '0;
        if (diag_on) begin
            unique case (ctrl0_reg.mon_sel)
                2'h0: mon_next = 5'h01;
                2'h1: mon_next = 5'h02;
                2'h2: mon_next = 5'h04;
                2'h3: mon_next = ctrl0_reg.mon_alt ? 5'h10 : 5'h08;
            endcase
        end
        // pin drives only while diag_on and not used as pulse input
        mon_oe_next = diag_on && !pwm_en_reg[8] && !pwm_en_reg[9];
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_comb begin
        rdata_next = `DRV_REG_RESET;
        if (reg_rd) begin
            unique case (reg_addr)
                `DRV_CTRL0_ADDR: begin
                    rdata_next[`DRV_ON_LSB +: NUM_OUT] = ctrl0_reg.on;
                    rdata_next[`DRV_DUTY_BIT]          = ctrl0_reg.duty_long;
                    rdata_next[`DRV_MON_ALT_BIT]       = ctrl0_reg.mon_alt;
                    rdata_next[`DRV_MON_SEL_LSB +: 2]  = ctrl0_reg.mon_sel;
                    rdata_next[`DRV_RECOV_DIS_BIT]     = ctrl0_reg.recov_dis;
                    rdata_next[`DRV_ACTIVE_BIT]        = ctrl0_reg.active;
                end
                `DRV_CTRL1_ADDR: begin
                    rdata_next[`DRV_LOW_LSB +: NUM_OUT]  = recov_en_reg;
                    rdata_next[`DRV_HIGH_LSB +: NUM_OUT] = pwm_en_reg;
                end
                `DRV_STAT0_ADDR: begin
                    rdata_next[`DRV_LOW_LSB +: NUM_OUT]  = oc_flag_reg;
                    rdata_next[`DRV_HIGH_LSB +: NUM_OUT] = ol_flag_reg;
                end
                `DRV_STAT1_ADDR: begin
                    rdata_next[`DRV_OV_BIT +: 4]     = sup_flag_reg;
                    rdata_next[`DRV_ST_ACTIVE_BIT]   = ctrl0_reg.active;
                end
                default: rdata_next = `DRV_REG_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl0_reg    <= '0;
            recov_en_reg <= '0;
            pwm_en_reg   <= '0;
            oc_flag_reg  <= '0;
            ol_flag_reg  <= '0;
            sup_flag_reg <= '0;
            rdata_reg    <= '0;
            out_en_reg   <= '0;
            mon_reg      <= '0;
            mon_oe_reg   <= 1'b0;
        end else begin
            ctrl0_reg    <= ctrl0_next;
            recov_en_reg <= recov_en_next;
            pwm_en_reg   <= pwm_en_next;
            oc_flag_reg  <= oc_flag_next;
            ol_flag_reg  <= ol_flag_next;
            sup_flag_reg <= sup_flag_next;
            rdata_reg    <= rdata_next;
            out_en_reg   <= out_en_next;
            mon_reg      <= mon_next;
            mon_oe_reg   <= mon_oe_next;
        end
    end

    // analog current image leaves through the pad, digital level is low
    assign monitor_and_second_pulse_pin_out = 1'b0;
    assign monitor_and_second_pulse_pin_oe  = mon_oe_reg;
    assign reg_rdata      = rdata_reg;
    assign out_enable     = out_en_reg;
    assign monitor_select = mon_reg;
endmodule

// ==== dv/drv_prot_checker_sva.sv ====
// Purpose: port-level checks of the driver protection block
// Assumes: filter length handed on from the design
// Notes:   counters give the long persistence spans
`include "drv_regs.svh"
module drv_prot_checker
    import drv_pkg::*;
#(
    parameter int NUM_OUT       = 11,
    parameter int DIAG_FILT_CYC = 6400
) (
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               reset_n,
    // register port
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    // comparators
    input wire logic               logic_supply_low,
    input wire logic [NUM_OUT-1:0] overcurrent_raw,
    input wire logic               supply_overvoltage_raw,
    input wire logic               supply_undervoltage_raw,
    input wire logic               temp_shutdown_raw,
    // outputs
    input wire logic               monitor_and_second_pulse_pin_oe,
    input wire logic [NUM_OUT-1:0] out_enable,
    input wire logic [4:0]         monitor_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // margin covers sync flops and the output register
    localparam int LIM = DIAG_FILT_CYC + 6;
    int   flt_reg [3];
    int   flt_next[3];
    int   oc_reg;
    int   oc_next;
    logic [2:0] fault;
    assign fault = {temp_shutdown_raw, supply_undervoltage_raw, supply_overvoltage_raw};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            flt_next[i] = fault[i] ? flt_reg[i] + 1 : 0;
        end
        oc_next = |(out_enable & overcurrent_raw) ? oc_reg + 1 : 0;
    end
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            flt_reg[i] <= reset_n ? flt_next[i] : 0;
        end
        oc_reg <= reset_n ? oc_next : 0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence standby_wr;
        reg_wr && reg_addr == `DRV_CTRL0_ADDR && !reg_wdata[`DRV_ACTIVE_BIT];
    endsequence
    sequence supply_gone;
        logic_supply_low [*4];
    endsequence
    a_standby_off: assert property (standby_wr |-> ##2 out_enable == '0)
        else $error("outputs on after standby write");
    a_standby_pin: assert property (standby_wr |-> ##2 !monitor_and_second_pulse_pin_oe)
        else $error("monitor pin driven in standby");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data without read strobe");
    a_logic_low_off: assert property (supply_gone |=> out_enable == '0)
        else $error("outputs on with logic supply low");
    a_over_volt_off: assert property (flt_reg[0] > LIM |-> out_enable == '0)
        else $error("outputs on during overvoltage");
    a_under_volt_off: assert property (flt_reg[1] > LIM |-> out_enable == '0)
        else $error("outputs on during undervoltage");
    a_shutdown_off: assert property (flt_reg[2] > LIM |-> out_enable == '0)
        else $error("outputs on during thermal shutdown");
    a_oc_on_limit: assert property (oc_reg <= LIM + 2)
        else $error("overloaded output left on");
    a_mon_one_hot: assert property ($onehot0(monitor_select))
        else $error("monitor select not one-hot");
endmodule

bind driver_protection_diagnostics drv_prot_checker #(
    .NUM_OUT(NUM_OUT), .DIAG_FILT_CYC(DIAG_FILT_CYC)
) drv_prot_checker_inst (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .logic_supply_low, .overcurrent_raw, .supply_overvoltage_raw,
    .supply_undervoltage_raw, .temp_shutdown_raw,
    .monitor_and_second_pulse_pin_oe, .out_enable, .monitor_select
);

// ==== dv/mcu_model.sv ====
// Purpose: controlling microcontroller as register port master
// Assumes: slave never stalls, read data one cycle later
// Notes:   strobes are one cycle, driven right after an edge
module mcu_model (
    // clock
    input  wire logic        ref_clk,
    // register port
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ==== dv/driver_protection_diagnostics_bench.sv ====
// Purpose: self-checking bench of the driver protection block
// Assumes: short filters, 8 and 20 cycles
// Notes:   comparator inputs are plain levels from the bench
`include "drv_regs.svh"
module driver_protection_diagnostics_bench
    import drv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, reset_n = 0, reg_wr, reg_rd, logic_supply_low = 0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [10:0] overcurrent_raw = '0, open_load_raw = '0, out_enable;
    logic        supply_overvoltage_raw = 0, supply_undervoltage_raw = 0;
    logic        temp_warning_raw = 0, temp_shutdown_raw = 0, first_pulse_width_input = 0;
    logic        pwm2_drv = 1, monitor_and_second_pulse_pin_in;
    logic        monitor_and_second_pulse_pin_out, monitor_and_second_pulse_pin_oe;
    logic [4:0]  monitor_select;
    int          n_fail = 0, num_checks = 0;
    // wire level from whichever side drives the pin
    assign monitor_and_second_pulse_pin_in = monitor_and_second_pulse_pin_oe ?
        monitor_and_second_pulse_pin_out : pwm2_drv;
    always #2.5 ref_clk = ~ref_clk;
    always #62.5 first_pulse_width_input <= ~first_pulse_width_input;
    driver_protection_diagnostics #(.DIAG_FILT_CYC(8), .OL_FILT_CYC(20))
        driver_protection_diagnostics_inst (.*);
    mcu_model mcu_model_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic results;
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        @(negedge ref_clk);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        mcu_model_inst.rd(a, d);
        chk("register read", exp, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mcu_model_inst.wr(a, d);
    endtask
    task automatic outs(input int n, input logic [10:0] exp);
        cyc(n);
        @(negedge ref_clk);
        chk("out_enable", 32'(exp), 32'(out_enable));
    endtask
    initial begin
        cyc(20000);
        n_fail++;
        results;
    end
    initial begin
        cyc(6);
        reset_n <= 1;
        rdc(`DRV_CTRL0_ADDR, '0);
        rdc(`DRV_STAT0_ADDR, '0);
        rdc(`DRV_STAT1_ADDR, '0);
        rdc(8'h10, '0);
        wr(`DRV_CTRL0_ADDR, 32'h0080_07f7);
        outs(4, 11'h7f7);
        open_load_raw <= 11'h7ff;
        temp_warning_raw <= 1;
        outs(60, 11'h7f7);
        rdc(`DRV_STAT0_ADDR, 32'h07f7_0000);
        rdc(`DRV_STAT1_ADDR, 32'h0000_0014);
        open_load_raw <= '0;
        temp_warning_raw <= 0;
        // let the filters drop first, a set beats a clear
        cyc(4);
        wr(`DRV_STAT0_ADDR, 32'hffff_ffff);
        wr(`DRV_STAT1_ADDR, 32'h0000_001f);
        rdc(`DRV_STAT0_ADDR, '0);
        wr(`DRV_CTRL0_ADDR, 32'h0080_07ff);
        overcurrent_raw <= 11'h004;
        outs(30, 11'h7fb);
        rdc(`DRV_STAT0_ADDR, 32'h0000_0004);
        overcurrent_raw <= '0;
        outs(30, 11'h7fb);
        wr(`DRV_STAT0_ADDR, 32'h0000_0004);
        outs(4, 11'h7ff);
        // recovery on: off for 7 filter spans, then back with flag still set
        wr(`DRV_CTRL1_ADDR, 32'h0000_0004);
        overcurrent_raw <= 11'h004;
        outs(14, 11'h7fb);
        overcurrent_raw <= '0;
        outs(30, 11'h7fb);
        outs(40, 11'h7ff);
        rdc(`DRV_STAT0_ADDR, 32'h0000_0004);
        // bursts shorter than the filter must never latch
        repeat (3) begin
            supply_overvoltage_raw <= 1;
            cyc(6);
            supply_overvoltage_raw <= 0;
            cyc(1);
        end
        rdc(`DRV_STAT1_ADDR, 32'h0000_0010);
        supply_overvoltage_raw <= 1;
        outs(30, '0);
        rdc(`DRV_STAT1_ADDR, 32'h0000_0011);
        supply_overvoltage_raw <= 0;
        outs(10, 11'h7ff);
        wr(`DRV_STAT1_ADDR, 32'h0000_0001);
        wr(`DRV_CTRL0_ADDR, 32'h0090_07ff);
        supply_undervoltage_raw <= 1;
        outs(30, '0);
        supply_undervoltage_raw <= 0;
        outs(10, '0);
        wr(`DRV_STAT1_ADDR, 32'h0000_0002);
        outs(4, 11'h7ff);
        temp_shutdown_raw <= 1;
        outs(30, '0);
        wr(`DRV_STAT1_ADDR, 32'h0000_0008);
        temp_shutdown_raw <= 0;
        outs(10, '0);
        wr(`DRV_STAT1_ADDR, 32'h0000_0008);
        outs(4, 11'h7ff);
        for (int i = 0; i < 4; i++) begin
            wr(`DRV_CTRL0_ADDR, 32'h0080_07ff | (32'(i) << 18));
            cyc(3);
            @(negedge ref_clk);
            chk("monitor_select", 32'h1 << i, 32'(monitor_select));
        end
        wr(`DRV_CTRL0_ADDR, 32'h008e_07ff);
        cyc(3);
        @(negedge ref_clk);
        chk("monitor_select", 32'h10, 32'(monitor_select));
        @(negedge ref_clk);
        chk("pin_oe", 32'h1, 32'(monitor_and_second_pulse_pin_oe));
        wr(`DRV_CTRL1_ADDR, 32'h0300_0000);
        cyc(3);
        @(negedge ref_clk);
        chk("pin_oe", '0, 32'(monitor_and_second_pulse_pin_oe));
        pwm2_drv <= 0;
        outs(6, 11'h4ff);
        temp_warning_raw <= 1;
        cyc(30);
        temp_warning_raw <= 0;
        logic_supply_low <= 1;
        outs(8, '0);
        logic_supply_low <= 0;
        rdc(`DRV_STAT1_ADDR, 32'h0000_0010);
        wr(`DRV_CTRL0_ADDR, '0);
        outs(3, '0);
        rdc(`DRV_CTRL1_ADDR, '0);
        rdc(`DRV_STAT1_ADDR, '0);
        results;
    end
endmodule
